// ==== rtl/ppfm_pkg.sv ====
package ppfm_pkg;
  // Port widths
  localparam int PPFM_AD_W = 6;
  localparam int PPFM_L_W = 6;
  localparam int PPFM_P_W = 6;
  localparam int PPFM_S_W = 4;
  localparam int PPFM_T_W = 4;
  localparam int PPFM_E_W = 2;
  localparam int PPFM_HC_W = 3;
  // Pin positions
  localparam int PPFM_PP_IRQ = 5;
  localparam int PPFM_PP_NMI = 1;
  localparam int PPFM_PP_OC0 = 0;
  localparam int PPFM_PP_OC2 = 2;
  localparam int PPFM_PS_TRIG_A = 2;
  localparam int PPFM_PS_TRIG_B = 3;
  localparam int PPFM_PT_CLKOUT = 2;
  localparam int PPFM_PT_CAP = 3;
  // Driver source select encodings
  localparam logic [1:0] PPFM_SEL_REG = 2'h0;
  localparam logic [1:0] PPFM_SEL_PWM = 2'h1;
  localparam logic [1:0] PPFM_SEL_ALT = 2'h2;
  localparam logic [1:0] PPFM_SEL_OC = 2'h3;
  // Reset values
  localparam logic [5:0] PPFM_RST_DIR6 = 6'h00;
  localparam logic [5:0] PPFM_RST_DIEN6 = 6'h00;
  localparam logic [3:0] PPFM_RST_PULL4 = 4'hf;
  // Glitch filter length in cycles
  localparam int PPFM_FILT_CYC = 3;
  typedef enum logic [1:0] {PPFM_IDLE, PPFM_ARMED, PPFM_LOCKED} ppfm_lock_t;
endpackage

// ==== rtl/ppfm_filter.sv ====
`timescale 1ns/1ps
module ppfm_filter import ppfm_pkg::*; #(
  parameter int LEN = PPFM_FILT_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic pin_in,
  input wire logic enable,
  output logic level,
  output logic fall
);
  typedef struct packed {
    logic [7:0] cnt;
    logic level;
    logic fall;
  } ppfm_flt_t;
  ppfm_flt_t st, next_st;
  always_comb begin
    next_st = st;
    next_st.fall = 1'b0;
    if (!enable || pin_in == st.level) begin
      next_st.cnt = 8'h00;
    end else if (st.cnt >= 8'(LEN - 1)) begin
      next_st.cnt = 8'h00;
      next_st.level = pin_in;
      next_st.fall = !pin_in;
    end else begin
      next_st.cnt = st.cnt + 8'h01;
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '{cnt: 8'h00, level: 1'b1, fall: 1'b0};
    end else begin
      st <= next_st;
    end
  end
  assign level = st.level;
  assign fall = st.fall;
endmodule // ppfm_filter

// ==== rtl/ppfm_mux.sv ====
`timescale 1ns/1ps
// What this block does
// [R01] A routed function leaves its default pin; never two pins at once.
// [R02] Shared pin output comes from highest-priority enabled function.
// [R03] Inputs of a shared pin all see the pin level concurrently.
// [R04] Debug pin is mode-select input during reset, debug I/O afterwards.
// [R05] Trigger a from PWM4 pin, b from PWM5 pin, rerouteable; c,d unused.
// [R06] HV input buffers enabled only by port L enable bits, not ADC bits.
// [R07] Periodic-unit clock output drives timer port pin two when enabled.
// [R08] Analog/digital port input buffers are off after reset.
// [R09] Port L pins are input-only HV inputs with interrupt and wakeup.
// [R10] Port P pin 5 interrupt input outranks PWM, trigger and GPIO.
// [R11] Port P pins 0 and 2 give PWM, supply output and over-current flags.
// [R12] Port P pins have direction, pull enable and pull polarity bits; ports AD, S and T have direction bits but no pull bits.
// [R13] Port S pins have per-pin open-drain output mode.
// [R14] High-current port P pins have reduced-drive control.
// [R15] Ports AD, P, L have per-pin interrupt enable and flag bits.
// [R16] Interrupt pins are glitch filtered before setting flags.
// [R17] Serial 0 / line receive path can feed timer 1 capture channel 1.
// [R18] Driver inputs select PWM, timer compare, or own register bit.
// [R19] One control register enables port E and debug pin pulls.
// [R20] Control bits configure interrupt pin and enable free clock output.
// [R21] Routing bits write once in normal mode, any time in special mode.
// [R22] Output enable follows top enabled output function, else direction.
module ppfm_mux import ppfm_pkg::*; (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic special_mode,
  // Routing control
  input wire logic route_wr,
  input wire logic [1:0] hs0_sel,
  input wire logic [1:0] hs1_sel,
  input wire logic [1:0] ls0_sel,
  input wire logic [1:0] ls1_sel,
  input wire logic [1:0] ls2_sel,
  input wire logic pwm4_trigger_route_bit,
  input wire logic pwm5_trigger_route_bit,
  input wire logic capture_from_rx,
  output logic route_locked,
  // Peripheral sources
  input wire logic [7:0] pwm_out,
  input wire logic [1:0] oc0_out,
  input wire logic [1:0] oc1_out,
  input wire logic [1:0] hs_reg,
  input wire logic [2:0] ls_reg,
  input wire logic serial0_rx,
  input wire logic periodic_unit_clock_out,
  input wire logic periodic_clk_en,
  input wire logic free_running_clock_out,
  input wire logic free_clk_enable,
  // Driver inputs
  output logic [1:0] high_side_driver,
  output logic [1:0] low_side_driver,
  output logic second_low_side_driver,
  // Trigger and capture
  output logic adc_trigger_in_a,
  output logic adc_trigger_in_b,
  output logic adc_trigger_in_c,
  output logic adc_trigger_in_d,
  output logic timer1_capture_ch1,
  // Debug pin
  input wire logic debug_pin_in,
  input wire logic debug_out,
  input wire logic debug_oe,
  output logic debug_pin_out,
  output logic debug_pin_oen,
  output logic mode_select_input,
  output logic debug_rx,
  // Pull control for port E and debug pin
  input wire logic debug_pull_en,
  input wire logic port_e_pull_dn_en,
  output logic debug_pull_up,
  output logic [1:0] port_e_pull_dn,
  // Port P
  input wire logic [5:0] pp_in,
  input wire logic [5:0] pp_dout,
  input wire logic [5:0] pp_dir,
  input wire logic [5:0] pp_pull_en,
  input wire logic [5:0] pp_pull_dn,
  input wire logic [2:0] pp_reduced_drive,
  input wire logic [5:0] pp_int_en,
  input wire logic [5:0] pp_int_rise,
  input wire logic [5:0] pp_flag_clr,
  input wire logic [1:0] pp_ovc_det,
  input wire logic [1:0] pp_ovc_int_en,
  input wire logic [1:0] pp_ovc_clr,
  input wire logic [1:0] pp_supply_en,
  input wire logic irq_pin_enable,
  input wire logic irq_edge_mode,
  output logic [5:0] pp_out,
  output logic [5:0] pp_oen,
  output logic [5:0] pp_pull_on,
  output logic [5:0] pp_pull_up,
  output logic [2:0] pp_reduced,
  output logic [1:0] pp_supply_on,
  output logic [5:0] pp_data_in,
  output logic [5:0] pp_flag,
  output logic [1:0] pp_ovc_flag,
  output logic irq_request,
  output logic nonmaskable_interrupt_pin,
  // Port AD
  input wire logic [5:0] ad_in,
  input wire logic [5:0] ad_dout,
  input wire logic [5:0] ad_dir,
  input wire logic [5:0] ad_dien,
  input wire logic [5:0] ad_int_en,
  input wire logic [5:0] ad_int_rise,
  input wire logic [5:0] ad_flag_clr,
  output logic [5:0] ad_out,
  output logic [5:0] ad_oen,
  output logic [5:0] ad_data_in,
  output logic [5:0] ad_flag,
  // Port L, high-voltage inputs
  input wire logic [5:0] high_voltage_input,
  input wire logic [5:0] hv_input_digital_enable,
  input wire logic [5:0] adc_digital_enable_bits,
  input wire logic [5:0] pl_int_en,
  input wire logic [5:0] pl_int_rise,
  input wire logic [5:0] pl_flag_clr,
  output logic [5:0] pl_data_in,
  output logic [5:0] pl_flag,
  // Port S
  input wire logic [3:0] ps_in,
  input wire logic [3:0] ps_dout,
  input wire logic [3:0] ps_dir,
  input wire logic [3:0] ps_open_drain,
  input wire logic [1:0] serial1_tx,
  output logic [3:0] ps_out,
  output logic [3:0] ps_oen,
  output logic [3:0] ps_data_in,
  // Port T
  input wire logic [3:0] pt_in,
  input wire logic [3:0] pt_dout,
  input wire logic [3:0] pt_dir,
  output logic [3:0] pt_out,
  output logic [3:0] pt_oen,
  output logic [3:0] pt_data_in,
  output logic key_wakeup
);
  typedef struct packed {
    ppfm_lock_t lock;
    logic [1:0] hs0;
    logic [1:0] hs1;
    logic [1:0] ls0;
    logic [1:0] ls1;
    logic [1:0] ls2;
    logic trig_a_rt;
    logic trig_b_rt;
    logic cap_rx;
    logic mode_cap;
    logic [5:0] ad_f;
    logic [5:0] pl_f;
    logic [5:0] pp_f;
    logic [1:0] ovc_f;
    logic [5:0] ad_prev;
    logic [5:0] pl_prev;
    logic [5:0] pp_prev;
    logic [5:0] ad_dq;
    logic [5:0] pl_dq;
    logic [5:0] pp_dq;
  } ppfm_state_t;
  ppfm_state_t st, next_st;
  logic [17:0] raw_in;
  logic [17:0] flt_lvl;
  logic [17:0] flt_fall;
  logic [17:0] flt_en;
  logic [5:0] pl_dig;
  logic [5:0] ad_dig;
  logic pwm4_on_pp;
  logic pwm5_on_pp;
  logic pwm5_on_ls0;
  logic pwm4_on_hs1;
  logic oc11_on_hs1;

  assign pl_dig = high_voltage_input & hv_input_digital_enable; // R06 R09
  assign ad_dig = ad_in & ad_dien; // R08
  assign raw_in = {pp_in, high_voltage_input, ad_in};
  // Pin 5 filter also runs for the interrupt input when that is enabled
  assign flt_en = {pp_int_en | {irq_pin_enable, 5'h00}, pl_int_en & hv_input_digital_enable,
    ad_int_en & ad_dien}; // R10 R16

  genvar gi;
  generate
    for (gi = 0; gi < 18; gi++) begin : g_flt
      ppfm_filter #(.LEN(PPFM_FILT_CYC)) u_flt ( // R16
        .core_clk(core_clk),
        .resetn(resetn),
        .pin_in(raw_in[gi]),
        .enable(flt_en[gi]),
        .level(flt_lvl[gi]),
        .fall(flt_fall[gi])
      );
    end
  endgenerate

  // One route per function: moving a function clears its default pin
  assign pwm4_on_hs1 = (st.hs1 == PPFM_SEL_ALT); // R01
  assign pwm5_on_ls0 = (st.ls0 == PPFM_SEL_ALT); // R01
  assign pwm4_on_pp = !st.trig_a_rt && !pwm4_on_hs1; // R01
  assign pwm5_on_pp = !st.trig_b_rt && !pwm5_on_ls0; // R01
  assign oc11_on_hs1 = (st.hs1 == PPFM_SEL_OC); // R01

  always_comb begin
    next_st = st;
    // Mode strap caught on the first edge after release
    next_st.mode_cap = 1'b1; // R04
    // Route bits lock after first write unless in special mode
    if (route_wr && (special_mode || st.lock != PPFM_LOCKED)) begin // R21
      next_st.hs0 = hs0_sel;
      next_st.hs1 = hs1_sel;
      next_st.ls0 = ls0_sel;
      next_st.ls1 = ls1_sel;
      next_st.ls2 = (hs1_sel == PPFM_SEL_OC && ls2_sel == PPFM_SEL_OC) ? PPFM_SEL_REG : ls2_sel;
      next_st.trig_a_rt = pwm4_trigger_route_bit;
      next_st.trig_b_rt = pwm5_trigger_route_bit;
      next_st.cap_rx = capture_from_rx;
      next_st.lock = special_mode ? PPFM_ARMED : PPFM_LOCKED;
    end
    next_st.ad_dq = ad_int_rise;
    next_st.pl_dq = pl_int_rise;
    next_st.pp_dq = pp_int_rise;
    next_st.ad_prev = flt_lvl[5:0];
    next_st.pl_prev = flt_lvl[11:6];
    next_st.pp_prev = flt_lvl[17:12];
    // Set wins over clear
    next_st.ad_f = (st.ad_f & ~ad_flag_clr) | (ad_int_en & ((flt_fall[5:0] & ~ad_int_rise) |
      (flt_lvl[5:0] & ~st.ad_prev & ad_int_rise))); // R15
    next_st.pl_f = (st.pl_f & ~pl_flag_clr) | (pl_int_en & ((flt_fall[11:6] & ~pl_int_rise) |
      (flt_lvl[11:6] & ~st.pl_prev & pl_int_rise))); // R09 R15
    next_st.pp_f = (st.pp_f & ~pp_flag_clr) | (pp_int_en & ((flt_fall[17:12] & ~pp_int_rise) |
      (flt_lvl[17:12] & ~st.pp_prev & pp_int_rise))); // R15
    next_st.ovc_f = (st.ovc_f & ~pp_ovc_clr) | pp_ovc_det; // R11
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Debug pin: input-only while in reset
  assign mode_select_input = debug_pin_in; // R04
  assign debug_pin_out = debug_out;
  assign debug_pin_oen = !(resetn && st.mode_cap && debug_oe); // R04
  assign debug_rx = debug_pin_in;
  assign debug_pull_up = debug_pull_en; // R19
  assign port_e_pull_dn = {PPFM_E_W{port_e_pull_dn_en}}; // R19

  // Driver sources
  always_comb begin
    case (st.hs0) // R18
      PPFM_SEL_PWM: high_side_driver[0] = pwm_out[3];
      PPFM_SEL_OC: high_side_driver[0] = oc1_out[0];
      default: high_side_driver[0] = hs_reg[0];
    endcase
    case (st.hs1) // R18
      PPFM_SEL_PWM: high_side_driver[1] = pwm_out[1];
      PPFM_SEL_ALT: high_side_driver[1] = pwm_out[4];
      PPFM_SEL_OC: high_side_driver[1] = oc1_out[1];
      default: high_side_driver[1] = hs_reg[1];
    endcase
    case (st.ls0) // R18
      PPFM_SEL_PWM: low_side_driver[0] = pwm_out[6];
      PPFM_SEL_ALT: low_side_driver[0] = pwm_out[5];
      PPFM_SEL_OC: low_side_driver[0] = oc0_out[0];
      default: low_side_driver[0] = ls_reg[0];
    endcase
    case (st.ls1) // R18
      PPFM_SEL_PWM: low_side_driver[1] = pwm_out[7];
      PPFM_SEL_OC: low_side_driver[1] = oc0_out[1];
      default: low_side_driver[1] = ls_reg[1];
    endcase
    case (st.ls2) // R18
      PPFM_SEL_PWM: second_low_side_driver = pwm_out[2];
      PPFM_SEL_OC: second_low_side_driver = oc11_on_hs1 ? ls_reg[2] : oc1_out[1]; // R01
      default: second_low_side_driver = ls_reg[2];
    endcase
  end

  // Port P output priority
  always_comb begin
    pp_out = pp_dout;
    pp_oen = ~pp_dir; // R12 R22
    if (pwm4_on_pp) begin // R02 R22
      pp_out[4] = pwm_out[4];
      pp_oen[4] = 1'b0;
    end
    if (pwm5_on_pp) begin // R02
      pp_out[5] = pwm_out[5];
      pp_oen[5] = 1'b0;
    end
    if (irq_pin_enable) begin // R10 R20
      pp_oen[5] = 1'b1;
    end
    if (st.hs0 != PPFM_SEL_PWM) begin // R01 R02
      pp_out[3] = pwm_out[3];
      pp_oen[3] = 1'b0;
    end
    if (st.ls2 != PPFM_SEL_PWM) begin // R01 R11
      pp_out[2] = pwm_out[2];
      pp_oen[2] = 1'b0;
    end
    if (st.hs1 != PPFM_SEL_PWM) begin // R01
      pp_out[1] = pwm_out[1];
      pp_oen[1] = 1'b0;
    end
    pp_out[0] = pwm_out[0]; // R11
    pp_oen[0] = 1'b0;
  end
  assign pp_pull_on = pp_pull_en; // R12
  assign pp_pull_up = ~pp_pull_dn; // R12
  assign pp_reduced = pp_reduced_drive; // R14
  assign pp_supply_on = pp_supply_en & ~st.ovc_f; // R11
  assign pp_data_in = pp_in; // R03
  assign pp_flag = st.pp_f;
  assign pp_ovc_flag = st.ovc_f & pp_ovc_int_en; // R11
  assign irq_request = irq_pin_enable && (irq_edge_mode ? flt_fall[12 + PPFM_PP_IRQ] :
    !flt_lvl[12 + PPFM_PP_IRQ]); // R10 R16 R20
  assign nonmaskable_interrupt_pin = pp_in[PPFM_PP_NMI]; // R03

  // Port AD and L
  assign ad_out = ad_dout;
  assign ad_oen = ~ad_dir; // R12
  assign ad_data_in = ad_dig; // R03 R08
  assign ad_flag = st.ad_f;
  assign pl_data_in = pl_dig; // R06
  assign pl_flag = st.pl_f;
  assign key_wakeup = |{st.ad_f, st.pl_f, st.pp_f};
  // ADC bits for port L channels are deliberately not read
  logic unused_adc_dien;
  assign unused_adc_dien = ^adc_digital_enable_bits; // R06

  // Port S: trigger reroute pins and open drain
  always_comb begin
    ps_out = ps_dout;
    ps_oen = ~ps_dir; // R12
    ps_out[1] = serial1_tx[0];
    ps_oen[1] = 1'b0;
    ps_out[3] = free_clk_enable ? free_running_clock_out : serial1_tx[1]; // R20
    if (free_clk_enable) begin
      ps_oen[3] = 1'b0;
    end
    for (int i = 0; i < PPFM_S_W; i++) begin
      if (ps_open_drain[i] && ps_out[i]) begin // R13
        ps_oen[i] = 1'b1;
      end
    end
  end
  assign ps_data_in = ps_in; // R03
  assign adc_trigger_in_a = st.trig_a_rt ? ps_in[PPFM_PS_TRIG_A] : pp_in[4]; // R05 R03
  assign adc_trigger_in_b = st.trig_b_rt ? ps_in[PPFM_PS_TRIG_B] : pp_in[5]; // R05 R03
  assign adc_trigger_in_c = 1'b0; // R05
  assign adc_trigger_in_d = 1'b0; // R05

  // Port T
  always_comb begin
    pt_out = pt_dout;
    pt_oen = ~pt_dir; // R22
    if (periodic_clk_en) begin // R07 R02
      pt_out[PPFM_PT_CLKOUT] = periodic_unit_clock_out;
      pt_oen[PPFM_PT_CLKOUT] = 1'b0;
    end
  end
  assign pt_data_in = pt_in;
  assign timer1_capture_ch1 = st.cap_rx ? serial0_rx : pt_in[PPFM_PT_CAP]; // R17
  assign route_locked = (st.lock == PPFM_LOCKED);
endmodule // ppfm_mux

// ==== verif/ppfm_pin_model.sv ====
`timescale 1ns/1ps
module ppfm_pin_model #(
  parameter int W = 6
) (
  input wire logic core_clk,
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] oen,
  input wire logic [W-1:0] pull_on,
  input wire logic [W-1:0] pull_up,
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] pin
);
  logic [W-1:0] wander = '0;
  // A floating pin keeps changing so no stale level passes for a real one
  always @(posedge core_clk) wander <= ~wander;
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!oen[i]) pin[i] = out[i];
      else if (ext_en[i]) pin[i] = ext_val[i];
      else if (pull_on[i]) pin[i] = pull_up[i];
      else pin[i] = wander[i];
    end
  end
endmodule // ppfm_pin_model

// ==== verif/ppfm_mux_properties.sv ====
`timescale 1ns/1ps
module ppfm_mux_properties (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic special_mode,
  input wire logic route_wr,
  input wire logic route_locked,
  input wire logic adc_trigger_in_c,
  input wire logic adc_trigger_in_d,
  input wire logic debug_oe,
  input wire logic debug_out,
  input wire logic debug_pin_out,
  input wire logic debug_pin_oen,
  input wire logic irq_pin_enable,
  input wire logic [5:0] pp_oen,
  input wire logic [5:0] pp_flag,
  input wire logic [5:0] pp_flag_clr,
  input wire logic [5:0] ad_dien,
  input wire logic [5:0] ad_data_in,
  input wire logic [5:0] hv_input_digital_enable,
  input wire logic [5:0] pl_data_in
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  sequence s_norm_wr;
    route_wr && !special_mode;
  endsequence
  sequence s_held;
    route_locked [*3];
  endsequence
  chk_lock_sets: assert property (s_norm_wr |=> s_held)
    else $error("route lock missing");
  chk_trig_idle: assert property (!adc_trigger_in_c && !adc_trigger_in_d)
    else $error("spare trigger active");
  chk_dbg_reset: assert property ($rose(resetn) |-> $past(debug_pin_oen))
    else $error("debug pin driven in reset");
  chk_dbg_drive: assert property (debug_oe && $past(resetn) |-> !debug_pin_oen && debug_pin_out == debug_out)
    else $error("debug pin not driven");
  chk_irq_input: assert property (irq_pin_enable |-> pp_oen[5])
    else $error("irq pin driven");
  chk_pl_gate: assert property ((pl_data_in & ~hv_input_digital_enable) == 6'h00)
    else $error("hv input not gated");
  chk_ad_gate: assert property ((ad_data_in & ~ad_dien) == 6'h00)
    else $error("ad input not gated");
  chk_flag_hold: assert property (($past(pp_flag) & ~pp_flag & ~$past(pp_flag_clr)) == 6'h00)
    else $error("flag dropped without clear");
endmodule // ppfm_mux_properties
bind ppfm_mux ppfm_mux_properties prop_u (.*);

// ==== verif/ppfm_mux_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end
module ppfm_mux_tb_top import ppfm_pkg::*;;
  logic core_clk = '0, resetn = '0, special_mode = '0, route_wr = '0, capture_from_rx = '0;
  logic pwm4_trigger_route_bit = '0, pwm5_trigger_route_bit = '0, periodic_clk_en = '0;
  logic free_clk_enable = '0, debug_pull_en = '0, port_e_pull_dn_en = '0, irq_pin_enable = '0;
  logic irq_edge_mode, serial0_rx, periodic_unit_clock_out, free_running_clock_out;
  logic debug_pin_in, debug_out, debug_oe;
  logic [1:0] hs1_sel = '0, ls0_sel = '0, hs0_sel, ls1_sel, ls2_sel;
  logic [1:0] pp_ovc_det = '0, pp_ovc_int_en = '0, pp_ovc_clr = '0, pp_supply_en = '0;
  logic [1:0] oc0_out, oc1_out, hs_reg, serial1_tx;
  logic [2:0] ls_reg, pp_reduced_drive = '0;
  logic [7:0] pwm_out;
  logic [5:0] pp_dout, ad_in, ad_dout, high_voltage_input, adc_digital_enable_bits, pp_ext_v;
  logic [5:0] pp_dir = '0, pp_int_en = '0, pp_int_rise = '0, pp_flag_clr = '0, ad_dir = '0;
  logic [5:0] ad_dien = '0, hv_input_digital_enable = '0, pp_ext_en = '0, pp_in;
  logic [5:0] pp_pull_en, pp_pull_dn, pl_int_en, pl_int_rise, ad_int_en, ad_int_rise;
  logic [5:0] ad_flag_clr, pl_flag_clr;
  logic [3:0] ps_dout, pt_in, pt_dout, ps_ext_v, ps_ext_en, ps_in, pt_dir;
  logic [3:0] ps_dir = '0, ps_open_drain = '0;
  logic route_locked, second_low_side_driver, adc_trigger_in_a, adc_trigger_in_b;
  logic adc_trigger_in_c, adc_trigger_in_d, timer1_capture_ch1, debug_pin_out, debug_pin_oen;
  logic mode_select_input, debug_rx, debug_pull_up, irq_request, nonmaskable_interrupt_pin;
  logic key_wakeup;
  logic [1:0] high_side_driver, low_side_driver, port_e_pull_dn, pp_supply_on, pp_ovc_flag;
  logic [2:0] pp_reduced;
  logic [5:0] pp_out, pp_oen, pp_pull_on, pp_pull_up, pp_data_in, pp_flag, ad_out, ad_oen;
  logic [5:0] ad_data_in, ad_flag, pl_data_in, pl_flag;
  logic [3:0] ps_out, ps_oen, ps_data_in, pt_out, pt_oen, pt_data_in;
  logic [31:0] seed = 32'h000173b3;
  int errors = 0, compares = 0, cycles = 0;

  ppfm_mux dut_u (.*);
  ppfm_pin_model #(.W(6)) pp_pins (.core_clk, .out(pp_out), .oen(pp_oen), .pull_on(pp_pull_on),
    .pull_up(pp_pull_up), .ext_en(pp_ext_en), .ext_val(pp_ext_v), .pin(pp_in));
  ppfm_pin_model #(.W(4)) ps_pins (.core_clk, .out(ps_out), .oen(ps_oen), .pull_on(4'h0),
    .pull_up(4'h0), .ext_en(ps_ext_en), .ext_val(ps_ext_v), .pin(ps_in));

  initial forever #2.5 core_clk = ~core_clk;

  function automatic logic [31:0] rn();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // Driver source picked by a 2-bit select: reg, own PWM, alternate PWM, compare
  function automatic logic pick(input logic [1:0] s, input logic [3:0] v);
    return v[s];
  endfunction

  task automatic rnd();
    logic [31:0] r [5];
    foreach (r[i]) r[i] = rn();
    {pwm_out, oc0_out, oc1_out, hs_reg, ls_reg, serial0_rx, periodic_unit_clock_out,
      free_running_clock_out, debug_pin_in, debug_out, debug_oe} <= r[0][22:0];
    {pp_dout, ad_in, ad_dout, high_voltage_input, adc_digital_enable_bits} <= r[1][29:0];
    {ps_dout, pt_in, pt_dout, serial1_tx, pp_ext_v, ps_ext_v, ps_ext_en} <= r[2][27:0];
    {pp_pull_en, pp_pull_dn, pl_int_en, pl_int_rise, ad_int_en} <= r[3][29:0];
    {ad_int_rise, ad_flag_clr, pl_flag_clr, hs0_sel, ls1_sel, ls2_sel, pt_dir,
      irq_edge_mode} <= r[4][28:0];
  endtask

  task automatic wr();
    route_wr <= 1'b1;
    @(posedge core_clk);
    route_wr <= 1'b0;
    rnd();
    @(negedge core_clk);
  endtask

  task automatic end_of_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_of_test();
    end
  end

  initial begin
    rnd();
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    `CHK(mode_select_input, debug_pin_in)
    `CHK(debug_pin_oen, 1'b1)
    @(posedge core_clk);
    resetn <= 1'b1;
    @(negedge core_clk);
    `CHK({ad_data_in, pl_data_in}, 12'h000)
    `CHK(route_locked, 1'b0)
    repeat (8) begin
      @(posedge core_clk);
      rnd();
      {ad_dien, hv_input_digital_enable} <= seed[11:0];
      @(negedge core_clk);
      `CHK(pl_data_in, high_voltage_input & hv_input_digital_enable)
      `CHK(ad_data_in, ad_in & ad_dien)
    end
    for (int s = 0; s < 4; s++) begin
      @(posedge core_clk);
      {special_mode, pp_dir} <= {1'b1, 6'h10};
      {hs1_sel, ls0_sel} <= {2{2'(s)}};
      {pwm4_trigger_route_bit, pwm5_trigger_route_bit, capture_from_rx} <= {s[0], s[0], s[1]};
      wr();
      `CHK(high_side_driver[1], pick(2'(s), {oc1_out[1], pwm_out[4], pwm_out[1], hs_reg[1]}))
      `CHK(low_side_driver[0], pick(2'(s), {oc0_out[0], pwm_out[5], pwm_out[6], ls_reg[0]}))
      `CHK(adc_trigger_in_a, s[0] ? ps_in[2] : pp_in[4])
      `CHK(adc_trigger_in_b, s[0] ? ps_in[3] : pp_in[5])
      `CHK(pp_data_in[5], pp_in[5])
      `CHK(timer1_capture_ch1, s[1] ? serial0_rx : pt_in[3])
      `CHK(pp_out[4], s == 0 ? pwm_out[4] : pp_dout[4])
      `CHK(ps_oen[2], 1'b1)
    end
    @(posedge core_clk);
    special_mode <= 1'b0;
    {hs1_sel, pwm4_trigger_route_bit, pwm5_trigger_route_bit, capture_from_rx} <= 5'h00;
    wr();
    `CHK(route_locked, 1'b1)
    @(posedge core_clk);
    {hs1_sel, pwm4_trigger_route_bit} <= {PPFM_SEL_PWM, 1'b1};
    wr();
    `CHK({high_side_driver[1], adc_trigger_in_a}, {hs_reg[1], pp_in[4]})
    @(posedge core_clk);
    rnd();
    {periodic_clk_en, free_clk_enable, irq_pin_enable, debug_pull_en, port_e_pull_dn_en} <= 5'h1f;
    {ps_dir, ps_open_drain, pp_dir, pp_reduced_drive} <= {4'h4, 4'h4, 6'h3f, 3'h5};
    @(negedge core_clk);
    `CHK({pt_out[2], pt_oen[2]}, {periodic_unit_clock_out, 1'b0})
    `CHK(ps_out[3], free_running_clock_out)
    `CHK(ps_oen[2], ps_dout[2])
    `CHK(pp_reduced, 3'h5)
    `CHK({debug_pull_up, port_e_pull_dn}, 3'h7)
    `CHK(pp_out[0], pwm_out[0])
    @(posedge core_clk);
    {irq_pin_enable, pp_dir, pp_ext_en, pp_ext_v} <= {1'b0, 6'h00, 6'h3f, 6'h00};
    {pp_int_en, pp_int_rise, pwm_out} <= {6'h08, 6'h08, 8'h00};
    // Pin 3 may carry PWM3 or the far side, so both move together
    // Pulses shorter than the filter must not set the flag
    for (int g = 1; g < PPFM_FILT_CYC; g++) begin
      repeat (8) @(posedge core_clk);
      {pp_ext_v, pwm_out} <= {6'h08, 8'h08};
      repeat (g) @(posedge core_clk);
      {pp_ext_v, pwm_out} <= {6'h00, 8'h00};
    end
    repeat (8) @(posedge core_clk);
    {pp_ext_v, pwm_out} <= {6'h08, 8'h08};
    @(negedge core_clk);
    `CHK(pp_flag[3], 1'b0)
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    `CHK(pp_flag, 6'h08)
    `CHK(key_wakeup, 1'b1)
    @(posedge core_clk);
    pp_flag_clr <= 6'h08;
    @(posedge core_clk);
    pp_flag_clr <= 6'h00;
    {pp_supply_en, pp_ovc_int_en, pp_ovc_det} <= 6'h3d;
    repeat (4) @(posedge core_clk);
    pp_ovc_det <= 2'h0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    `CHK(pp_flag[3], 1'b0)
    `CHK({pp_ovc_flag, pp_supply_on}, 4'h6)
    @(posedge core_clk);
    pp_ovc_clr <= 2'h1;
    @(posedge core_clk);
    pp_ovc_clr <= 2'h0;
    @(negedge core_clk);
    `CHK(pp_ovc_flag, 2'h0)
    @(posedge core_clk);
    resetn <= 1'b0;
    @(negedge core_clk);
    `CHK({route_locked, pp_flag, pp_ovc_flag}, 9'h000)
    end_of_test();
  end
endmodule // ppfm_mux_tb_top
